//--- sacc_params.svh
// Constants of the converter control block: register fields, reset values, timing
// Functional notes
// - High-active chip select must be high for any bus access.
// - Low-active chip select must be low for any bus access.
// - Data-ready output serves as interrupt request and buffer fill indication.
// - Data-ready polarity selectable high or low, as level or pulse.
// - Ten-bit three-state data bus, writes in, results out, bit 0 is LSB.
// - Two address inputs select which control register a write targets.
// - Strobe input acts as read/write direction or as active-low write select.
// - Separate read strobe honoured only in write-select strobe configuration.
// - Configuration selects internal or external reference; external disables internal drive.
// - Four inputs individually enabled, single-ended or paired, sampled at one instant.
// - Eight-stage pipeline; first stage takes new sample while seven older proceed.
// - Single mode converts only on start pulse, timed by internal oscillator.
// - Single mode: start falling edge holds all selected inputs and starts conversion.
// - Continuous mode starts a conversion on every conversion clock falling edge while at least one input is enabled.
// - Control register 0 bit 1 set selects single mode, clear selects continuous.
// - Continuous mode: first data-ready comes seven clocks plus trigger level after reset.
// - Data-ready becomes active when buffered sample count reaches trigger level.
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH
`define SACC_DATA_W 10
`define SACC_CHANNELS 4
`define SACC_STAGES 8
`define SACC_FIFO_DEPTH 16
`define SACC_ADDR_CR0 2'h0
`define SACC_ADDR_CR1 2'h1
`define SACC_CR0_REF_EXT 0
`define SACC_CR0_SINGLE 1
`define SACC_CR0_STROBE_WO 2
`define SACC_CR0_DRDY_HIGH 3
`define SACC_CR0_DRDY_PULSE 4
`define SACC_CR0_FIFO_RST 5
`define SACC_CR1_CHEN_LSB 0
`define SACC_CR1_DIFF_AB 4
`define SACC_CR1_DIFF_CD 5
`define SACC_CR1_TL_LSB 6
`define SACC_CR0_RESET 10'h000
`define SACC_CR1_RESET 10'h001
`define SACC_CLK_PERIOD_PS 5000
`define SACC_OSC_PERIOD_PS 166667
`define SACC_OSC_CYCLES ((`SACC_OSC_PERIOD_PS) / (`SACC_CLK_PERIOD_PS))
`define SACC_PIPE_LATENCY 7
`endif

//--- sacc_pkg.sv
// Types shared by the converter control block
package sacc_pkg;
  typedef enum logic [1:0] {sacc_idle, sacc_scan, sacc_flush} sacc_state_t;
  typedef logic [9:0] sacc_word_t;
endpackage

//--- sacc_pipeline.sv
// Conversion pipeline: samples advance one stage per conversion tick
`timescale 1ns/1ps
`default_nettype none
module sacc_pipeline #(
  parameter int STAGES = 8,
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic tick,
  input wire logic flush,
  // Sample in
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  // Result out
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  output logic busy
);
  logic [STAGES-2:0] vld;
  logic [WIDTH-1:0] dat [STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Stage one takes a new sample while later stages hold older ones
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      vld <= '0;
    end else if (tick) begin
      vld <= {vld[STAGES-3:0], in_valid};
    end
  end

  always_ff @(posedge clk) begin
    if (tick) begin
      dat[0] <= in_data;
    end
  end

  genvar g;
  generate
    for (g = 1; g < STAGES - 1; g++) begin : g_stage
      always_ff @(posedge clk) begin
        if (tick) begin
          dat[g] <= dat[g-1];
        end
      end
    end
  endgenerate

  // Last stage completes on the tick after the seventh shift
  assign out_valid = tick & vld[STAGES-2] & ~flush;
  assign out_data = dat[STAGES-2];
  assign busy = |vld;
endmodule
`default_nettype wire

//--- sacc_top.sv
// Conversion control and host interface of the four-input pipelined converter
`timescale 1ns/1ps
`default_nettype none
`include "sacc_params.svh"
module sacc_top #(
  parameter int OSC_CYCLES = `SACC_OSC_CYCLES,
  parameter int FIFO_DEPTH = `SACC_FIFO_DEPTH,
  parameter int CHANNELS = `SACC_CHANNELS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host bus
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic reg_addr_bit0,
  input wire logic reg_addr_bit1,
  input wire logic host_strobe,
  input wire logic read_strobe_n,
  input wire logic [9:0] data_bus_in,
  output logic [9:0] data_bus_out,
  output logic data_bus_oe,
  output logic data_ready_flag,
  // Conversion clock or start pin
  input wire logic conversion_clock_in,
  // Analog front end
  input wire logic [CHANNELS*10-1:0] sample_codes,
  output logic hold_pulse,
  output logic ref_internal_drive_en
);
  localparam int PW = $clog2(FIFO_DEPTH);

  sacc_pkg::sacc_word_t cr0;
  sacc_pkg::sacc_word_t cr1;
  sacc_pkg::sacc_state_t state;
  sacc_pkg::sacc_word_t fifo_mem [FIFO_DEPTH];
  sacc_pkg::sacc_word_t held [CHANNELS];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [PW:0] count;
  logic sel, sel_q, strobe_q, read_q, conv_q, level_q;
  logic wo_mode, single_mode, write_evt, read_active, read_end;
  logic fifo_rst, conv_fall, osc_tick, tick, emit, fifo_wr, pipe_busy;
  logic [5:0] osc_cnt;
  logic [3:0] eff, remaining, cur_mask, tl;
  logic [1:0] chan;
  logic pipe_valid;
  sacc_pkg::sacc_word_t pipe_data;
  sacc_pkg::sacc_word_t conv_in;

  function automatic logic [1:0] lowest_idx(input logic [3:0] m);
    lowest_idx = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host bus decode
  assign sel = ~chip_select_low_n & chip_select_high;
  assign wo_mode = cr0[`SACC_CR0_STROBE_WO];
  assign single_mode = cr0[`SACC_CR0_SINGLE];
  // Write-select mode writes on strobe fall; direction mode on select start
  assign write_evt = wo_mode ? (sel & ~host_strobe & strobe_q)
                             : (sel & ~sel_q & ~host_strobe);
  // Read strobe counts only in write-select mode
  assign read_active = wo_mode ? (sel & ~read_strobe_n) : (sel & host_strobe);
  assign read_end = read_q & ~read_active;
  assign data_bus_oe = read_active;
  assign fifo_rst = write_evt && {reg_addr_bit1, reg_addr_bit0} == `SACC_ADDR_CR0
                    && data_bus_in[`SACC_CR0_FIFO_RST];

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q <= 1'b0;
      strobe_q <= 1'b1;
      read_q <= 1'b0;
      conv_q <= 1'b0;
    end else begin
      sel_q <= sel;
      strobe_q <= host_strobe;
      read_q <= read_active;
      conv_q <= conversion_clock_in;
    end
  end

  // Control registers; reset bit is a strobe and is not stored
  always_ff @(posedge clk) begin
    if (reset) begin
      cr0 <= `SACC_CR0_RESET;
      cr1 <= `SACC_CR1_RESET;
    end else if (write_evt) begin
      if ({reg_addr_bit1, reg_addr_bit0} == `SACC_ADDR_CR0) begin
        cr0 <= data_bus_in & ~(10'h001 << `SACC_CR0_FIFO_RST);
      end else if ({reg_addr_bit1, reg_addr_bit0} == `SACC_ADDR_CR1) begin
        cr1 <= data_bus_in;
      end
    end
  end

  assign ref_internal_drive_en = ~cr0[`SACC_CR0_REF_EXT];

  ////////////////////////////////////////////////////////////////////////////
  // Channel selection and trigger level
  always_comb begin
    eff = cr1[`SACC_CR1_CHEN_LSB +: 4];
    eff[1] = eff[1] & ~cr1[`SACC_CR1_DIFF_AB];
    eff[3] = eff[3] & ~cr1[`SACC_CR1_DIFF_CD];
    tl = cr1[`SACC_CR1_TL_LSB +: 4];
    if (tl == 4'h0) begin
      tl = 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillator, runs only while a single conversion is in flight
  always_ff @(posedge clk) begin
    if (reset || !single_mode || state == sacc_pkg::sacc_idle) begin
      osc_cnt <= '0;
    end else if (osc_cnt == 6'(OSC_CYCLES - 1)) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + 6'h01;
    end
  end

  assign osc_tick = single_mode && state != sacc_pkg::sacc_idle
                    && osc_cnt == 6'(OSC_CYCLES - 1);
  assign conv_fall = conv_q & ~conversion_clock_in;
  assign tick = single_mode ? osc_tick : conv_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer
  assign cur_mask = (!single_mode && remaining == 4'h0) ? eff : remaining;
  assign chan = lowest_idx(cur_mask);
  assign emit = tick && cur_mask != 4'h0
                && (!single_mode || state == sacc_pkg::sacc_scan);
  // All enabled inputs held together at the start of a scan
  assign hold_pulse = single_mode
    ? (conv_fall && state == sacc_pkg::sacc_idle && eff != 4'h0)
    : (conv_fall && remaining == 4'h0 && eff != 4'h0);

  always_ff @(posedge clk) begin
    if (reset || fifo_rst) begin
      state <= sacc_pkg::sacc_idle;
      remaining <= 4'h0;
    end else begin
      case (state)
        sacc_pkg::sacc_idle: begin
          if (hold_pulse && single_mode) begin
            state <= sacc_pkg::sacc_scan;
            remaining <= eff;
          end else if (!single_mode && emit) begin
            remaining <= cur_mask & ~(4'h1 << chan);
          end
        end
        sacc_pkg::sacc_scan: begin
          if (!single_mode) begin
            state <= sacc_pkg::sacc_idle;
            remaining <= 4'h0;
          end else if (emit) begin
            remaining <= cur_mask & ~(4'h1 << chan);
            if ((cur_mask & ~(4'h1 << chan)) == 4'h0) begin
              state <= sacc_pkg::sacc_flush;
            end
          end
        end
        sacc_pkg::sacc_flush: begin
          if (!single_mode || (!pipe_busy && !tick)) begin
            state <= sacc_pkg::sacc_idle;
          end
        end
        default: begin
          state <= sacc_pkg::sacc_idle;
        end
      endcase
    end
  end

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_hold
      always_ff @(posedge clk) begin
        if (hold_pulse) begin
          held[c] <= sample_codes[c*10 +: 10];
        end
      end
    end
  endgenerate

  // First channel of a continuous-mode scan converts the value held in this same cycle
  assign conv_in = hold_pulse ? sample_codes[chan*10 +: 10] : held[chan];

  sacc_pipeline #(
    .STAGES(`SACC_STAGES),
    .WIDTH(`SACC_DATA_W)
  ) u_pipe (
    .clk(clk),
    .reset(reset),
    .tick(tick),
    .flush(fifo_rst),
    .in_valid(emit),
    .in_data(conv_in),
    .out_valid(pipe_valid),
    .out_data(pipe_data),
    .busy(pipe_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result buffer
  assign fifo_wr = pipe_valid && count != (PW+1)'(FIFO_DEPTH);

  always_ff @(posedge clk) begin
    if (fifo_wr) begin
      fifo_mem[wr_ptr] <= pipe_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || fifo_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (fifo_wr) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (read_end && count != '0) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(fifo_wr) - (PW+1)'(read_end && count != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      data_bus_out <= 10'h000;
    end else begin
      data_bus_out <= fifo_mem[rd_ptr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-ready output
  logic level;
  logic active;
  assign level = count >= {1'b0, tl};
  assign active = cr0[`SACC_CR0_DRDY_PULSE] ? (level & ~level_q) : level;

  always_ff @(posedge clk) begin
    if (reset) begin
      level_q <= 1'b0;
      data_ready_flag <= 1'b1;
    end else begin
      level_q <= level;
      data_ready_flag <= cr0[`SACC_CR0_DRDY_HIGH] ? active : ~active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [3:0] ticks_since_rst;
  logic wrote_since_rst;
  always_ff @(posedge clk) begin
    if (reset || fifo_rst) begin
      ticks_since_rst <= 4'h0;
      wrote_since_rst <= 1'b0;
    end else begin
      if (tick && ticks_since_rst != 4'hf) begin
        ticks_since_rst <= ticks_since_rst + 4'h1;
      end
      if (fifo_wr) begin
        wrote_since_rst <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_cr0_write;
    write_evt && {reg_addr_bit1, reg_addr_bit0} == `SACC_ADDR_CR0;
  endsequence
  sequence s_ext_ref_write;
    s_cr0_write and data_bus_in[`SACC_CR0_REF_EXT];
  endsequence

  AST_HIGH_CS: assert property (!chip_select_high |-> !data_bus_oe)
    else $error("bus driven with high select inactive");
  AST_LOW_CS: assert property (chip_select_low_n |-> !data_bus_oe)
    else $error("bus driven with low select inactive");
  AST_NO_WRITE_UNSEL: assert property (!sel |=> $stable(cr0) && $stable(cr1))
    else $error("register changed while not selected");
  AST_RD_IGNORED: assert property (!wo_mode && sel && !read_strobe_n && !host_strobe
    |-> !data_bus_oe)
    else $error("read strobe honoured in direction mode");
  AST_MODE_BIT: assert property (s_cr0_write |=> single_mode == $past(data_bus_in[1]))
    else $error("mode bit not taken from write");
  AST_EXT_REF: assert property (s_ext_ref_write |=> !ref_internal_drive_en)
    else $error("internal reference still driven");
  AST_SINGLE_START: assert property (single_mode && hold_pulse |-> conv_fall)
    else $error("single hold without start edge");
  AST_CONT_EDGE: assert property (!single_mode && emit |-> conv_fall)
    else $error("continuous conversion without clock edge");
  AST_LATENCY: assert property (!single_mode && fifo_wr && !wrote_since_rst
    |-> ticks_since_rst == 4'(`SACC_PIPE_LATENCY))
    else $error("first result not seven ticks after reset");
  AST_DRDY_LEVEL: assert property (!cr0[`SACC_CR0_DRDY_PULSE] && cr0[`SACC_CR0_DRDY_HIGH]
    && count >= {1'b0, tl} ##1 $stable(cr0) |-> data_ready_flag)
    else $error("data ready not active at trigger level");
  AST_DRDY_PULSE: assert property (cr0[`SACC_CR0_DRDY_PULSE] && $stable(cr0)
    && data_ready_flag == cr0[`SACC_CR0_DRDY_HIGH]
    |=> data_ready_flag != cr0[`SACC_CR0_DRDY_HIGH] || $changed(cr0))
    else $error("data ready pulse longer than one cycle");
endmodule
`default_nettype wire

//--- sacc_host_model.sv
// Host processor model driving the converter's parallel bus
`timescale 1ns/1ps
`default_nettype none
module sacc_host_model (
  // Clock
  input wire logic clk,
  // Bus towards the device
  output logic chip_select_low_n,
  output logic chip_select_high,
  output logic reg_addr_bit0,
  output logic reg_addr_bit1,
  output logic host_strobe,
  output logic read_strobe_n,
  output logic [9:0] data_bus_in,
  // Device side of the data bus
  input wire logic [9:0] data_bus_out,
  input wire logic data_bus_oe
);
  logic [9:0] drv = 10'h000;
  logic hdrv = 1'b0;
  initial begin
    chip_select_low_n = 1'b1;
    chip_select_high = 1'b0;
    {reg_addr_bit1, reg_addr_bit0} = 2'h0;
    host_strobe = 1'b1;
    read_strobe_n = 1'b1;
  end
  // Wire level; released bus shows the inverse of the last value
  assign data_bus_in = data_bus_oe ? data_bus_out : (hdrv ? drv : ~drv);
  //////////////////////////////////////////////////////////////////////////////
  // One bus access: sel = {high select, low select} asserted
  task automatic access(input logic rd, input logic [1:0] a, input logic [9:0] d,
      input logic [1:0] sel, input logic rsn, output logic [9:0] q, output logic o);
    @(posedge clk);
    chip_select_low_n <= ~sel[0];
    chip_select_high <= sel[1];
    {reg_addr_bit1, reg_addr_bit0} <= a;
    drv <= d;
    hdrv <= ~rd;
    host_strobe <= rd;
    read_strobe_n <= rsn;
    @(posedge clk);
    q = data_bus_out;
    o = data_bus_oe;
    chip_select_low_n <= 1'b1;
    chip_select_high <= 1'b0;
    host_strobe <= 1'b1;
    read_strobe_n <= 1'b1;
    hdrv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- sacc_top_tb_top.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sacc_top_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic conversion_clock_in = 1'b0;
  logic [39:0] sample_codes = 40'h0;
  logic chip_select_low_n, chip_select_high, reg_addr_bit0, reg_addr_bit1;
  logic host_strobe, read_strobe_n, data_bus_oe, data_ready_flag;
  logic hold_pulse, ref_internal_drive_en;
  logic [9:0] data_bus_in, data_bus_out, q_rd;
  logic o_rd;
  logic act_lvl = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int hold_cnt = 0;
  int act_cnt = 0;
  integer seed = 32'hacd9aa50;

  always #2.5 clk = ~clk;

  sacc_top #(.OSC_CYCLES(4)) sacc_top_i (.clk(clk), .reset(reset),
    .chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
    .reg_addr_bit0(reg_addr_bit0), .reg_addr_bit1(reg_addr_bit1),
    .host_strobe(host_strobe), .read_strobe_n(read_strobe_n),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .data_ready_flag(data_ready_flag), .conversion_clock_in(conversion_clock_in),
    .sample_codes(sample_codes), .hold_pulse(hold_pulse),
    .ref_internal_drive_en(ref_internal_drive_en));

  sacc_host_model sacc_host_model_i (.clk(clk), .chip_select_low_n(chip_select_low_n),
    .chip_select_high(chip_select_high), .reg_addr_bit0(reg_addr_bit0),
    .reg_addr_bit1(reg_addr_bit1), .host_strobe(host_strobe),
    .read_strobe_n(read_strobe_n), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));

  //////////////////////////////////////////////////////////////////////////////
  // Monitors and hang limit
  always @(posedge clk) begin
    cyc++;
    if (hold_pulse === 1'b1) hold_cnt++;
    if (data_ready_flag === act_lvl) act_cnt++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // One configuration: program, convert, check flag and holds, read back
  task automatic run(input logic [9:0] cr0, input logic [9:0] cr1, input int edges,
      input int nrd);
    int ch[$];
    logic [9:0] q[$];
    int n, tl, words;
    logic [39:0] snap;
    logic [63:0] r;
    for (int c = 0; c < 4; c++) begin
      if (cr1[c] && !(c == 1 && cr1[4]) && !(c == 3 && cr1[5])) ch.push_back(c);
    end
    n = ch.size();
    tl = (cr1[9:6] == 4'h0) ? 1 : int'(cr1[9:6]);
    sacc_host_model_i.access(1'b0, 2'h1, cr1, 2'b11, 1'b1, q_rd, o_rd);
    sacc_host_model_i.access(1'b0, 2'h0, cr0 | 10'h020, 2'b11, 1'b1, q_rd, o_rd);
    act_lvl = cr0[3];
    @(negedge clk);
    hold_cnt = 0;
    act_cnt = 0;
    for (int k = 1; k <= edges; k++) begin
      @(posedge clk);
      conversion_clock_in <= 1'b1;
      r = {$random(seed), $random(seed)};
      repeat (11) @(posedge clk);
      sample_codes <= r[39:0];
      repeat (12) @(posedge clk);
      // Edge spacing of 36 cycles keeps the host rate limits
      conversion_clock_in <= 1'b0;
      if ((k - 1) % n == 0) snap = r[39:0];
      if (cr0[1]) foreach (ch[i]) q.push_back(snap[ch[i]*10 +: 10]);
      else q.push_back(snap[ch[(k-1)%n]*10 +: 10]);
      repeat (12) @(posedge clk);
      if (!cr0[1] && !cr0[4]) begin
        chk(data_ready_flag === (act_lvl ^ (k < 7 + tl)), "flag timing");
      end
    end
    repeat (80) @(posedge clk);
    words = cr0[1] ? n : edges - 7;
    if (cr0[4]) chk(act_cnt == 1, "pulse count");
    else chk(data_ready_flag === (act_lvl ^ (words < tl)), "flag level");
    chk(hold_cnt == (edges + n - 1) / n, "hold count");
    for (int i = 0; i < nrd; i++) begin
      sacc_host_model_i.access(1'b1, 2'h0, 10'h000, 2'b11, !cr0[2], q_rd, o_rd);
      chk(q_rd === q.pop_front() && o_rd === 1'b1, "read word");
    end
    $display("test done cr0=%h cr1=%h", cr0, cr1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(data_ready_flag === 1'b1 && ref_internal_drive_en === 1'b1, "reset out");
    sacc_host_model_i.access(1'b0, 2'h0, 10'h001, 2'b01, 1'b1, q_rd, o_rd);
    sacc_host_model_i.access(1'b0, 2'h0, 10'h001, 2'b10, 1'b1, q_rd, o_rd);
    sacc_host_model_i.access(1'b0, 2'h2, 10'h001, 2'b11, 1'b0, q_rd, o_rd);
    chk(o_rd === 1'b0 && ref_internal_drive_en === 1'b1, "refused write");
    sacc_host_model_i.access(1'b0, 2'h0, 10'h001, 2'b11, 1'b1, q_rd, o_rd);
    chk(ref_internal_drive_en === 1'b0, "external ref");
    $display("test done selects");
    run(10'h000, 10'h041, 10, 3);
    run(10'h008, 10'h10f, 14, 4);
    run(10'h018, 10'h097, 12, 5);
    run(10'h00e, 10'h0ab, 1, 2);
    sacc_host_model_i.access(1'b0, 2'h0, 10'h001, 2'b11, 1'b1, q_rd, o_rd);
    chk(ref_internal_drive_en === 1'b0 && o_rd === 1'b0, "strobe write");
    $display("test done write select");
    summarize();
  end
endmodule
`default_nettype wire
